// File: inc/uarx_consts.vh
// Register offsets, field positions and reset values of the receive channel
`ifndef UARX_CONSTS_VH
`define UARX_CONSTS_VH

// Byte offsets on the register bus
`define UARX_OFF_MODE_ONE 8'h00
`define UARX_OFF_MODE_TWO 8'h04
`define UARX_OFF_STATUS 8'h08
`define UARX_OFF_RX_DATA 8'h0C
`define UARX_OFF_BAUD 8'h10

// Mode control one fields
`define UARX_M1_OP_MODE 0
`define UARX_M1_CLK_SRC 1
`define UARX_M1_CHAR_LO 2
`define UARX_M1_CHAR_HI 3
`define UARX_M1_STOP_LEN 4
`define UARX_M1_PAR_EN 5
`define UARX_M1_PAR_POL 6
`define UARX_M1_BIT_DIR 7

// Mode control two fields
`define UARX_M2_RX_EN 0
`define UARX_M2_IRQ_EN 1
`define UARX_M2_ERR_CLR 2

// Status fields
`define UARX_ST_FULL 0
`define UARX_ST_PAR_ERR 1
`define UARX_ST_FRM_ERR 2
`define UARX_ST_OVR_ERR 3
`define UARX_ST_BUSY 4

// Baud field positions
`define UARX_BD_PRE_LO 0
`define UARX_BD_PRE_HI 1
`define UARX_BD_RLD_LO 8
`define UARX_BD_RLD_HI 15

// Reset values
`define UARX_RST_MODE_ONE 8'h0C
`define UARX_RST_MODE_TWO 2'h0
`define UARX_RST_PRESCALE 2'h0
`define UARX_RST_RELOAD 8'h02

// Generator ticks per serial bit and sample phases
`define UARX_TICKS_PER_BIT 4
`define UARX_PHASE_AFTER_START 2'h0
`define UARX_PHASE_LAST 2'h3

`endif

// File: rtl/uarx_receiver.v
// Asynchronous serial receiver with baud generator and APB register file
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "uarx_consts.vh"

module uarx_receiver #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial line from remote transmitter
  input wire serial_input_line,
  // Receive interrupt request, level
  output reg rx_irq
);

  // Frame states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  // Software visible control
  reg [7:0] serial_mode_ctrl_one; // Frame format and mode
  reg receive_enable; // Receiver on
  reg receive_irq_enable; // Interrupt gate
  reg [1:0] prescaler_select; // Generator prescale code
  reg [7:0] baud_counter_reload; // Generator count
  // Status
  reg receive_full_flag;
  reg parity_error_flag;
  reg framing_error_flag;
  reg overrun_error_flag;
  reg [7:0] receive_data_reg;
  // Generator
  reg [2:0] pre_cnt; // Prescale counter
  reg [7:0] baud_cnt; // Reload down-counter
  reg baud_sample_clock; // One-cycle tick
  // Line synchroniser and receiver state
  reg line_meta; // First stage, read only by line_sync
  reg line_sync;
  reg [3:0] hist; // Last four line samples
  reg [2:0] state;
  reg [1:0] phase; // Tick within current bit
  reg [3:0] bit_idx; // Data or parity bit number
  reg [1:0] votes; // High samples in this bit
  reg [7:0] shift_reg;
  reg par_bit;
  // Bus decode helpers
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire sel_m1;
  wire sel_m2;
  wire sel_st;
  wire sel_rd;
  wire sel_bd;
  wire mapped;
  // Decoded format
  wire [3:0] char_len;
  wire par_en;
  wire par_pol;
  wire msb_first;
  wire async_mode;
  wire rx_run;
  // Bit decision
  wire [1:0] votes_now;
  wire bit_val;
  wire last_data;
  wire [7:0] data_mask;
  wire [3:0] msb_pos; // Slot of this bit when MSB first
  wire par_exp;
  wire frame_end;
  wire err_par;
  wire err_frm;
  wire err_ovr;
  wire frame_good;
  wire err_clr;
  reg [2:0] pre_max;

  // Access phase completes on the edge where pready is high
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign sel_m1 = (paddr == `UARX_OFF_MODE_ONE);
  assign sel_m2 = (paddr == `UARX_OFF_MODE_TWO);
  assign sel_st = (paddr == `UARX_OFF_STATUS);
  assign sel_rd = (paddr == `UARX_OFF_RX_DATA);
  assign sel_bd = (paddr == `UARX_OFF_BAUD);
  assign mapped = sel_m1 | sel_m2 | sel_st | sel_rd | sel_bd;
  assign err_clr = wr_acc & sel_m2 & pwdata[`UARX_M2_ERR_CLR];

  // Format fields
  assign char_len = {2'b00,
    serial_mode_ctrl_one[`UARX_M1_CHAR_HI:`UARX_M1_CHAR_LO]} + 4'h5;
  assign par_en = serial_mode_ctrl_one[`UARX_M1_PAR_EN];
  assign par_pol = serial_mode_ctrl_one[`UARX_M1_PAR_POL];
  assign msb_first = serial_mode_ctrl_one[`UARX_M1_BIT_DIR];
  assign async_mode = ~serial_mode_ctrl_one[`UARX_M1_OP_MODE];
  assign rx_run = receive_enable & async_mode;

  // Two of three samples at phases 1..3 decide the bit
  assign votes_now = votes + {1'b0, line_sync};
  assign bit_val = votes_now[1];
  assign msb_pos = char_len - 4'h1 - bit_idx;
  assign last_data = (bit_idx == char_len - 4'h1);
  assign data_mask = 8'hFF >> (4'h8 - char_len);
  // Even parity for 0, odd for 1, over data bits only
  assign par_exp = (^(shift_reg & data_mask)) ^ par_pol;
  // Decision instant of the first stop bit
  assign frame_end = baud_sample_clock & (state == ST_STOP)
    & (phase == `UARX_PHASE_LAST);
  assign err_par = par_en & (par_bit != par_exp);
  assign err_frm = ~bit_val;
  assign err_ovr = receive_full_flag;
  // Gated by the enable so a same-cycle disable never loads data
  assign frame_good = frame_end & rx_run & ~err_par & ~err_frm
    & ~err_ovr;

  // Prescale terminal count: 1, 2, 4 or 8 cycles per step
  always @*
  begin
    case (prescaler_select)
      2'b00: pre_max = 3'h0;
      2'b01: pre_max = 3'h1;
      2'b10: pre_max = 3'h3;
      default: pre_max = 3'h7;
    endcase
  end

  // Baud generator; reload 0 wraps to 256 steps
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt <= 3'h0;
      baud_cnt <= 8'h00;
      baud_sample_clock <= 1'b0;
    end
    else
    begin
      baud_sample_clock <= 1'b0;
      if (pre_cnt >= pre_max)
      begin
        pre_cnt <= 3'h0;
        // Count down reload steps per tick
        if (baud_cnt == 8'h00)
        begin
          baud_cnt <= baud_counter_reload - 8'h01;
          baud_sample_clock <= 1'b1;
        end
        else
        begin
          baud_cnt <= baud_cnt - 8'h01;
        end
      end
      else
      begin
        pre_cnt <= pre_cnt + 3'h1;
      end
    end
  end

  // Two-flop synchroniser for the serial pin
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end
    else
    begin
      line_meta <= serial_input_line;
      line_sync <= line_meta;
    end
  end

  // Frame engine, stepped by generator ticks
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      hist <= 4'hF;
      phase <= 2'h0;
      bit_idx <= 4'h0;
      votes <= 2'h0;
      shift_reg <= 8'h00;
      par_bit <= 1'b0;
    end
    else if (!rx_run)
    begin
      // Disable aborts at once; partial character dropped
      state <= ST_IDLE;
      hist <= 4'hF;
      phase <= 2'h0;
      votes <= 2'h0;
    end
    else if (baud_sample_clock)
    begin
      hist <= {hist[2:0], line_sync};
      case (state)
        ST_IDLE:
        begin
          // High followed by three lows marks start; idle is high
          if ({hist[2:0], line_sync} == 4'b1000)
          begin
            state <= ST_DATA;
            phase <= `UARX_PHASE_AFTER_START;
            bit_idx <= 4'h0;
            votes <= 2'h0;
            shift_reg <= 8'h00;
            par_bit <= 1'b0;
          end
        end
        ST_DATA:
        begin
          phase <= phase + 2'h1;
          if (phase == 2'h0)
          begin
            votes <= 2'h0;
          end
          else if (phase != `UARX_PHASE_LAST)
          begin
            votes <= votes_now;
          end
          else
          begin
            // Bit complete: first pass stores data bit 0 when LSB first, the top data bit when MSB first
            votes <= 2'h0;
            if (bit_idx == 4'hF)
            begin
              bit_idx <= 4'h0;
            end
            else if (bit_idx == char_len)
            begin
              par_bit <= bit_val;
              state <= ST_STOP;
            end
            else
            begin
              if (msb_first)
                shift_reg[msb_pos[2:0]] <= bit_val;
              else
                shift_reg[bit_idx[2:0]] <= bit_val;
              bit_idx <= bit_idx + 4'h1;
              if (last_data && !par_en)
                state <= ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          phase <= phase + 2'h1;
          if (phase == 2'h0)
            votes <= 2'h0;
          else if (phase != `UARX_PHASE_LAST)
            votes <= votes_now;
          else
            state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive data, full flag and sticky error flags
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_data_reg <= 8'h00;
      receive_full_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
    end
    else
    begin
      // Good frame loads data; set beats a same-cycle read
      if (frame_good)
      begin
        receive_data_reg <= shift_reg & data_mask;
        receive_full_flag <= 1'b1;
      end
      else if (rd_acc && sel_rd)
      begin
        receive_full_flag <= 1'b0;
      end
      // Errors hold until cleared; a new error wins over clear
      if (frame_end && rx_run && err_par)
        parity_error_flag <= 1'b1;
      else if (err_clr)
        parity_error_flag <= 1'b0;
      if (frame_end && rx_run && err_frm)
        framing_error_flag <= 1'b1;
      else if (err_clr)
        framing_error_flag <= 1'b0;
      if (frame_end && rx_run && err_ovr)
        overrun_error_flag <= 1'b1;
      else if (err_clr)
        overrun_error_flag <= 1'b0;
    end
  end

  // Control registers written over the bus
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_mode_ctrl_one <= `UARX_RST_MODE_ONE;
      receive_enable <= 1'b0;
      receive_irq_enable <= 1'b0;
      prescaler_select <= `UARX_RST_PRESCALE;
      baud_counter_reload <= `UARX_RST_RELOAD;
    end
    else if (wr_acc)
    begin
      // Address decode for writes
      if (sel_m1)
        serial_mode_ctrl_one <= pwdata[7:0];
      else if (sel_m2)
      begin
        receive_enable <= pwdata[`UARX_M2_RX_EN];
        receive_irq_enable <= pwdata[`UARX_M2_IRQ_EN];
      end
      else if (sel_bd)
      begin
        prescaler_select <= pwdata[`UARX_BD_PRE_HI:`UARX_BD_PRE_LO];
        baud_counter_reload <= pwdata[`UARX_BD_RLD_HI:`UARX_BD_RLD_LO];
      end
    end
  end

  // Bus answer: one wait cycle, registered read data
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite)
      begin
        // Address decode for reads; unmapped reads zero
        if (sel_m1)
          prdata <= {24'h00_0000, serial_mode_ctrl_one};
        else if (sel_m2)
          prdata <= {30'h0000_0000, receive_irq_enable, receive_enable};
        else if (sel_st)
          prdata <= {27'h000_0000, (state != ST_IDLE),
            overrun_error_flag, framing_error_flag,
            parity_error_flag, receive_full_flag};
        else if (sel_rd)
          prdata <= {24'h00_0000, receive_data_reg};
        else if (sel_bd)
          prdata <= {16'h0000, baud_counter_reload, 6'h00,
            prescaler_select};
      end
    end
  end

  // Interrupt request follows flags through the enable
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_irq <= 1'b0;
    else
      rx_irq <= receive_irq_enable & (receive_full_flag
        | parity_error_flag | framing_error_flag
        | overrun_error_flag);
  end

endmodule

// File: test/uarx_monitor.sv
// Port checker for the asynchronous receiver
`timescale 1ns/10ps
`include "uarx_consts.vh"
module uarx_monitor #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Serial line and interrupt
  input wire serial_input_line,
  input wire rx_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Offsets that answer without error
  wire mapped = paddr == `UARX_OFF_MODE_ONE || paddr == `UARX_OFF_MODE_TWO
    || paddr == `UARX_OFF_STATUS || paddr == `UARX_OFF_RX_DATA
    || paddr == `UARX_OFF_BAUD;
  // Bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> access_s)
    else $error("ready outside an access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address");
  rdata_zero_a: assert property (!(pready && !pwrite) |-> prdata == 0)
    else $error("read data not zero outside read");
  // Only a bus access can take a raised request down
  irq_drop_a: assert property ($fell(rx_irq) |->
    $past(pready, 1) || $past(pready, 2) || $past(pready, 3))
    else $error("interrupt dropped without access");
  // A raised request seen at a status read has a flag behind it
  irq_status_a: assert property (rx_irq && pready && !pwrite
    && paddr == `UARX_OFF_STATUS |-> prdata[3:0] != 0)
    else $error("interrupt with no status flag");
endmodule
bind uarx_receiver uarx_monitor #(.ADDR_W(ADDR_W)) i_uarx_monitor (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .serial_input_line(serial_input_line), .rx_irq(rx_irq));

// File: test/uarx_line_model.sv
// Remote asynchronous transmitter driving the serial line
`timescale 1ns/10ps
module uarx_line_model (
  // Clock
  input wire sys_clk,
  // Serial line
  output reg serial_input_line
);
  // Clocks per bit; moved off nominal to skew the rate
  int bit_cyc = 8;
  initial serial_input_line = 1'b1;
  // One bit, held a whole bit time
  task put(input logic v);
    begin
      serial_input_line <= v;
      repeat (bit_cyc) @(posedge sys_clk);
    end
  endtask
  // One frame in the format of mode one; stop value may be broken
  task send(input logic [7:0] d, input logic [7:0] m1, input logic par,
    input logic stp);
    int nb;
    begin
      nb = m1[3:2] + 5;
      put(1'b0);
      for (int i = 0; i < nb; i++)
        put(m1[7] ? d[nb-1-i] : d[i]);
      if (m1[5])
        put(par);
      put(stp);
      if (m1[4])
        put(1'b1);
      serial_input_line <= 1'b1;
    end
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the asynchronous receiver
`timescale 1ns/10ps
`include "uarx_consts.vh"
module tb_top;
  // Design inputs
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  // Design outputs and the serial line driven by the model
  wire [31:0] prdata;
  wire pready, pslverr, serial_input_line, rx_irq;
  // Bench state
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] last_d;
  // Case row: mode, baud, bit time, data, parity, stop, status
  typedef struct {
    logic [7:0] m1; logic [31:0] bd; int bc;
    logic [7:0] d; logic p; logic s; logic [3:0] st;
  } uarx_row_t;
  uarx_row_t rows [8] = '{
    '{8'h0C, 32'h0000_0200, 8, 8'hA5, 1'b0, 1'b1, 4'h1},
    '{8'h0C, 32'h0000_0A00, 41, 8'h5A, 1'b0, 1'b1, 4'h1},
    '{8'h0C, 32'h0000_0A00, 39, 8'hC3, 1'b0, 1'b1, 4'h1},
    '{8'h2C, 32'h0000_0200, 8, 8'h01, 1'b0, 1'b1, 4'h2},
    '{8'h0C, 32'h0000_0200, 8, 8'h3C, 1'b0, 1'b0, 4'h4},
    '{8'h90, 32'h0000_0201, 16, 8'h16, 1'b0, 1'b1, 4'h1},
    '{8'h24, 32'h0000_0202, 32, 8'h2B, 1'b0, 1'b1, 4'h1},
    '{8'hE8, 32'h0000_0203, 64, 8'h55, 1'b1, 1'b1, 4'h1}};
  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  uarx_receiver #(.ADDR_W(8)) i_uarx_receiver (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_input_line(serial_input_line),
    .rx_irq(rx_irq));
  uarx_line_model i_uarx_line_model (.sys_clk(sys_clk),
    .serial_input_line(serial_input_line));
  // Verdict and end of run
  task complete_run;
    begin
      if (n_errors == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      total_checks++;
      if (got !== exp)
      begin
        n_errors++;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One APB transfer; holds the request until ready, idle edge after
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
        n_errors++;
        complete_run();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
    end
  endtask
  // Bounded wait for the request
  task wait_irq;
    int n;
    begin
      n = 0;
      while (rx_irq !== 1'b1 && n < 400)
      begin
        @(posedge sys_clk);
        n++;
      end
      chk("irq", 32'h0000_0001, {31'h0, rx_irq});
      if (n >= 400)
        complete_run();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Table of frame formats, rates and errors
    foreach (rows[i])
    begin
      apb(1'b1, `UARX_OFF_BAUD, rows[i].bd);
      apb(1'b1, `UARX_OFF_MODE_ONE, {24'h0, rows[i].m1});
      apb(1'b1, `UARX_OFF_MODE_TWO, 32'h0000_0003);
      i_uarx_line_model.bit_cyc = rows[i].bc;
      i_uarx_line_model.send(rows[i].d, rows[i].m1, rows[i].p, rows[i].s);
      wait_irq();
      rdchk(`UARX_OFF_STATUS, {28'h0, rows[i].st}, "status");
      if (rows[i].st == 4'h1)
        last_d = rows[i].d;
      rdchk(`UARX_OFF_RX_DATA, {24'h0, last_d}, "data");
      rdchk(`UARX_OFF_STATUS, {28'h0, rows[i].st & 4'hE}, "status");
      apb(1'b1, `UARX_OFF_MODE_TWO, 32'h0000_0007);
      rdchk(`UARX_OFF_STATUS, 32'h0000_0000, "status");
    end
    // Reset in mid-run, then reset values and a refused address
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk(`UARX_OFF_MODE_ONE, 32'h0000_000C, "mode one");
    rdchk(`UARX_OFF_MODE_TWO, 32'h0000_0000, "mode two");
    rdchk(`UARX_OFF_BAUD, 32'h0000_0200, "baud");
    rdchk(8'h14, 32'h0000_0000, "unmapped");
    chk("slverr", 32'h0000_0001, {31'h0, er});
    // Overrun with the request masked
    i_uarx_line_model.bit_cyc = 8;
    apb(1'b1, `UARX_OFF_MODE_TWO, 32'h0000_0001);
    i_uarx_line_model.send(8'h11, 8'h0C, 1'b0, 1'b1);
    repeat (20) @(posedge sys_clk);
    chk("masked irq", 32'h0000_0000, {31'h0, rx_irq});
    i_uarx_line_model.send(8'h22, 8'h0C, 1'b0, 1'b1);
    repeat (20) @(posedge sys_clk);
    rdchk(`UARX_OFF_STATUS, 32'h0000_0009, "status");
    rdchk(`UARX_OFF_RX_DATA, 32'h0000_0011, "data");
    apb(1'b1, `UARX_OFF_MODE_TWO, 32'h0000_0005);
    // Disable in mid-frame drops the character
    fork
      i_uarx_line_model.send(8'h00, 8'h0C, 1'b0, 1'b1);
      begin
        repeat (30) @(posedge sys_clk);
        apb(1'b1, `UARX_OFF_MODE_TWO, 32'h0000_0000);
      end
    join
    apb(1'b1, `UARX_OFF_MODE_TWO, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    rdchk(`UARX_OFF_STATUS, 32'h0000_0000, "status");
    rdchk(`UARX_OFF_RX_DATA, 32'h0000_0011, "data");
    complete_run();
  end
endmodule
